// ==== rtl/ccr_bank.sv ====
// converter control register bank with strobe timing and end-of-line helpers
// Operation
// - nineteen 8-bit control registers, indexed from zero, steer the converter
// - registers with defaults load them at reset; others stay unspecified
// - writes land only from the listener message with secondary zero
// - register value is plain binary, bit 7 weight 128 down to 1
// - service request enable bits gate eight request sources; default 0x40
// - handshake register: direct output control, end-of-data enable, input status
// - format register picks handshake, polarities, time unit, width, direction, timeout
// - strobe lasts 25 us plus count times unit, at least 40 us
// - a zero count means 256 time units
// - sequence register enables detect, its length, insertion and insert count
// - eight registers hold insert characters, eighth-from-last through last
// - two registers hold the first and second detect characters
// - insert and detect registers hold full 8-bit character codes
// - last four registers are reserved and affect nothing
// - format 0xCA gives full, positive, 5 us, 8-bit unidirectional, no timeout
`timescale 1ns/1ns
`default_nettype none
`include "ccr_cfg.svh"
module ccr_bank #(
  parameter int BASE_CYC = `CCR_T_BASE_NS / `CCR_CLK_NS,
  parameter int MIN_CYC = (`CCR_T_MIN_NS + `CCR_CLK_NS - 1) / `CCR_CLK_NS,
  parameter int UNIT_LONG_CYC = `CCR_T_UNIT_LONG_NS / `CCR_CLK_NS,
  parameter int UNIT_SHORT_CYC = `CCR_T_UNIT_SHORT_NS / `CCR_CLK_NS
) (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire ccr_pkg::ccr_wr_type wr, // listener message register write
  input wire logic [4:0] rd_index, // register read index
  output logic [7:0] rd_data, // register read data
  input wire logic [7:0] req_src, // service request sources
  output logic srq_out, // gated service request
  output ccr_pkg::ccr_cfg_type cfg, // decoded configuration
  input wire logic core_data_ack, // converter core data ack, true level
  input wire logic core_ready, // converter core ready, true level
  input wire logic data_ack_in, // data ack pin in
  input wire logic ready_in, // ready pin in
  output logic data_ack_out, // data ack pin out
  output logic ready_out, // ready pin out
  output logic data_ack_in_true, // synced data ack, true level
  output logic ready_in_true, // synced ready, true level
  input wire logic strobe_start, // request a data valid pulse
  output logic strobe_busy, // pulse in progress
  output logic data_valid_out, // data valid pin out
  input wire logic insert_start, // emit end-of-line characters
  output logic ins_valid, // insert character valid
  input wire logic ins_ready, // insert character taken
  output logic [7:0] ins_char, // insert character
  input wire logic det_valid, // incoming character valid
  input wire logic [7:0] det_char, // incoming character
  output logic eol_detected // end-of-line seen pulse
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (BASE_CYC < 1 || MIN_CYC < 1 || UNIT_LONG_CYC < 1 || UNIT_SHORT_CYC < 1) begin : g_chk
    $error("ccr_bank: cycle counts must be at least one");
  end
  if (BASE_CYC + `CCR_PW_ZERO_UNITS * UNIT_LONG_CYC >= (1 << `CCR_DUR_W)) begin : g_chk_w
    $error("ccr_bank: pulse duration exceeds counter width");
  end

  // ----------------------------------------
  // register array
  // ----------------------------------------
  logic [7:0] regs_r [0:`CCR_NUM_REGS-1];
  logic wr_ok;
  assign wr_ok = wr.valid && (wr.secondary == `CCR_DDL_SEC);

  function automatic logic [7:0] ccr_default(input int idx);
    case (idx)
      `CCR_IDX_SRQ: ccr_default = `CCR_RST_SRQ;
      `CCR_IDX_HSCS: ccr_default = `CCR_RST_HSCS;
      `CCR_IDX_FMT: ccr_default = `CCR_RST_FMT;
      `CCR_IDX_PW: ccr_default = `CCR_RST_PW;
      default: ccr_default = `CCR_RST_EOLC;
    endcase
  endfunction

  for (genvar i = 0; i < `CCR_NUM_REGS; i++) begin : g_reg
    if (i < `CCR_NUM_DEFAULTED) begin : g_def
      always_ff @(posedge clock) begin
        if (rst) begin
          regs_r[i] <= ccr_default(i);
        end else if (wr_ok && wr.index == 5'(i)) begin
          if (i == `CCR_IDX_HSCS) begin
            regs_r[i] <= wr.data & `CCR_HSCS_WMASK;
          end else begin
            regs_r[i] <= wr.data;
          end
        end
      end
    end else begin : g_nodef
      // character and reserved slots keep whatever they hold
      always_ff @(posedge clock) begin
        if (wr_ok && wr.index == 5'(i)) begin
          regs_r[i] <= wr.data;
        end
      end
    end
  end

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  always_comb begin
    cfg.hs_option = regs_r[`CCR_IDX_FMT][`CCR_FMT_OPT_HI:`CCR_FMT_OPT_LO];
    cfg.data_neg = regs_r[`CCR_IDX_FMT][`CCR_FMT_DNEG];
    cfg.hs_neg = regs_r[`CCR_IDX_FMT][`CCR_FMT_HNEG];
    cfg.unit_short = regs_r[`CCR_IDX_FMT][`CCR_FMT_UNIT];
    cfg.wide16 = regs_r[`CCR_IDX_FMT][`CCR_FMT_WIDE];
    cfg.unidir = regs_r[`CCR_IDX_FMT][`CCR_FMT_UNI];
    cfg.timeout_en = regs_r[`CCR_IDX_FMT][`CCR_FMT_TMO];
    cfg.buf_empty_eod = regs_r[`CCR_IDX_HSCS][`CCR_HS_BEMPTY];
    cfg.detect_en = regs_r[`CCR_IDX_EOLC][`CCR_EOL_DET];
    cfg.detect_one = regs_r[`CCR_IDX_EOLC][`CCR_EOL_DET1];
    cfg.insert_en = regs_r[`CCR_IDX_EOLC][`CCR_EOL_INS];
    cfg.insert_cnt = regs_r[`CCR_IDX_EOLC][`CCR_EOL_CNT_HI:`CCR_EOL_CNT_LO];
  end

  // ----------------------------------------
  // service request
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      srq_out <= 1'b0;
    end else begin
      srq_out <= |(req_src & regs_r[`CCR_IDX_SRQ]);
    end
  end

  // ----------------------------------------
  // handshake pins
  // ----------------------------------------
  logic dai_s1_r, dai_s2_r, rdi_s1_r, rdi_s2_r;
  // free-running so the pin level is settled when reset ends
  always_ff @(posedge clock) begin
    dai_s1_r <= data_ack_in;
    dai_s2_r <= dai_s1_r;
    rdi_s1_r <= ready_in;
    rdi_s2_r <= rdi_s1_r;
  end
  assign data_ack_in_true = dai_s2_r ^ cfg.hs_neg;
  assign ready_in_true = rdi_s2_r ^ cfg.hs_neg;

  // pins rest at the idle level of the default polarity during reset
  localparam logic [7:0] RST_FMT = `CCR_RST_FMT;
  logic dack_true, rdy_true;
  always_comb begin
    if (regs_r[`CCR_IDX_HSCS][`CCR_HS_DIRECT]) begin
      dack_true = regs_r[`CCR_IDX_HSCS][`CCR_HS_DACK];
      rdy_true = regs_r[`CCR_IDX_HSCS][`CCR_HS_RDY];
    end else begin
      dack_true = core_data_ack;
      rdy_true = core_ready;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      data_ack_out <= RST_FMT[`CCR_FMT_HNEG];
      ready_out <= RST_FMT[`CCR_FMT_HNEG];
    end else begin
      data_ack_out <= dack_true ^ cfg.hs_neg;
      ready_out <= rdy_true ^ cfg.hs_neg;
    end
  end

  // ----------------------------------------
  // register readback
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_index == `CCR_IDX_HSCS) begin
      rd_data <= regs_r[`CCR_IDX_HSCS] | {5'h00, data_ack_in_true, 1'b0, ready_in_true};
    end else if (rd_index < 5'(`CCR_NUM_REGS)) begin
      rd_data <= regs_r[rd_index];
    end else begin
      rd_data <= 8'h00;
    end
  end

  // ----------------------------------------
  // data valid pulse
  // ----------------------------------------
  logic [8:0] pw_units;
  logic [`CCR_DUR_W-1:0] unit_cyc, dur_raw, dur;
  logic [`CCR_DUR_W-1:0] dv_cnt_r;
  logic dv_active_r;
  always_comb begin
    pw_units = (regs_r[`CCR_IDX_PW] == 8'h00) ? 9'(`CCR_PW_ZERO_UNITS) : {1'b0, regs_r[`CCR_IDX_PW]};
    unit_cyc = cfg.unit_short ? `CCR_DUR_W'(UNIT_SHORT_CYC) : `CCR_DUR_W'(UNIT_LONG_CYC);
    dur_raw = `CCR_DUR_W'(BASE_CYC) + `CCR_DUR_W'({13'h0000, pw_units} * unit_cyc);
    dur = (dur_raw < `CCR_DUR_W'(MIN_CYC)) ? `CCR_DUR_W'(MIN_CYC) : dur_raw;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      dv_active_r <= 1'b0;
      dv_cnt_r <= '0;
    end else if (!dv_active_r && strobe_start) begin
      dv_active_r <= 1'b1;
      dv_cnt_r <= dur - `CCR_DUR_W'(1);
    end else if (dv_active_r) begin
      if (dv_cnt_r == '0) begin
        dv_active_r <= 1'b0;
      end else begin
        dv_cnt_r <= dv_cnt_r - `CCR_DUR_W'(1);
      end
    end
  end
  assign strobe_busy = dv_active_r;
  assign data_valid_out = dv_active_r ^ cfg.hs_neg;

  // ----------------------------------------
  // end-of-line insertion
  // ----------------------------------------
  ccr_pkg::ccr_state_type ins_state_r;
  logic [4:0] ins_ptr_r, ins_first;
  assign ins_first = `CCR_IDX_INS_LAST - {2'b00, cfg.insert_cnt};
  always_ff @(posedge clock) begin
    if (rst) begin
      ins_state_r <= ccr_pkg::CCR_IDLE;
      ins_ptr_r <= `CCR_IDX_INS_LAST;
      ins_char <= 8'h00;
    end else begin
      case (ins_state_r)
        ccr_pkg::CCR_IDLE: begin
          if (insert_start && cfg.insert_en) begin
            ins_state_r <= ccr_pkg::CCR_EMIT;
            ins_ptr_r <= ins_first;
            ins_char <= regs_r[ins_first];
          end
        end
        ccr_pkg::CCR_EMIT: begin
          if (ins_ready) begin
            if (ins_ptr_r == `CCR_IDX_INS_LAST) begin
              ins_state_r <= ccr_pkg::CCR_IDLE;
            end else begin
              ins_ptr_r <= ins_ptr_r + 5'h01;
              ins_char <= regs_r[ins_ptr_r + 5'h01];
            end
          end
        end
        default: begin
          ins_state_r <= ccr_pkg::CCR_IDLE;
        end
      endcase
    end
  end
  assign ins_valid = (ins_state_r == ccr_pkg::CCR_EMIT);

  // ----------------------------------------
  // end-of-line detection
  // ----------------------------------------
  logic first_hit, prev_hit_r;
  assign first_hit = (det_char == regs_r[`CCR_IDX_DET_A]);
  always_ff @(posedge clock) begin
    if (rst) begin
      prev_hit_r <= 1'b0;
      eol_detected <= 1'b0;
    end else begin
      eol_detected <= 1'b0;
      if (det_valid) begin
        prev_hit_r <= first_hit;
        if (cfg.detect_en && cfg.detect_one) begin
          eol_detected <= first_hit;
        end else if (cfg.detect_en) begin
          eol_detected <= prev_hit_r && (det_char == regs_r[`CCR_IDX_DET_B]);
        end
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic [`CCR_DUR_W-1:0] len_cnt_r, exp_len_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      len_cnt_r <= '0;
      exp_len_r <= '0;
    end else if (!dv_active_r && strobe_start) begin
      len_cnt_r <= `CCR_DUR_W'(1);
      exp_len_r <= dur;
    end else if (dv_active_r) begin
      len_cnt_r <= len_cnt_r + `CCR_DUR_W'(1);
    end
  end

  reset_default_a: assert property (@(posedge clock) disable iff (rst)
    $fell(rst) |-> regs_r[`CCR_IDX_SRQ] == `CCR_RST_SRQ && regs_r[`CCR_IDX_FMT] == `CCR_RST_FMT
      && regs_r[`CCR_IDX_PW] == `CCR_RST_PW)
    else $error("register defaults not loaded");
  ddl_filter_a: assert property (@(posedge clock) disable iff (rst)
    wr.valid && wr.secondary != `CCR_DDL_SEC && wr.index == `CCR_IDX_FMT |=> $stable(regs_r[`CCR_IDX_FMT]))
    else $error("write with nonzero secondary changed a register");
  ddl_write_a: assert property (@(posedge clock) disable iff (rst)
    wr_ok && wr.index == `CCR_IDX_PW |=> regs_r[`CCR_IDX_PW] == $past(wr.data))
    else $error("listener write not stored");
  srq_gate_a: assert property (@(posedge clock) disable iff (rst)
    ##1 srq_out == |($past(req_src) & $past(regs_r[`CCR_IDX_SRQ])))
    else $error("service request gating wrong");
  direct_ctl_a: assert property (@(posedge clock) disable iff (rst)
    regs_r[`CCR_IDX_HSCS][`CCR_HS_DIRECT] && !cfg.hs_neg |=> ready_out == $past(regs_r[`CCR_IDX_HSCS][`CCR_HS_RDY]))
    else $error("direct ready control not followed");
  pulse_len_a: assert property (@(posedge clock) disable iff (rst)
    !$past(rst) && $fell(dv_active_r) |-> $past(len_cnt_r) == exp_len_r && exp_len_r >= `CCR_DUR_W'(MIN_CYC))
    else $error("data valid pulse length wrong");
  zero_units_a: assert property (@(posedge clock) disable iff (rst)
    regs_r[`CCR_IDX_PW] == 8'h00 && !cfg.unit_short |-> dur == `CCR_DUR_W'(BASE_CYC + `CCR_PW_ZERO_UNITS * UNIT_LONG_CYC))
    else $error("zero count not taken as 256 units");
  insert_order_a: assert property (@(posedge clock) disable iff (rst)
    ins_state_r == ccr_pkg::CCR_IDLE && insert_start && cfg.insert_en |=>
      ins_valid && ins_ptr_r == $past(ins_first) && ins_char == $past(regs_r[ins_first]))
    else $error("insertion did not start at the right character");
  insert_end_a: assert property (@(posedge clock) disable iff (rst)
    ins_valid && ins_ready && ins_ptr_r == `CCR_IDX_INS_LAST |=> !ins_valid)
    else $error("insertion did not end at the last character");
  detect_one_a: assert property (@(posedge clock) disable iff (rst)
    det_valid && cfg.detect_en && cfg.detect_one |=> eol_detected == $past(first_hit))
    else $error("single character detect wrong");
  hold_char_a: assert property (@(posedge clock) disable iff (rst)
    ins_valid && !ins_ready |=> ins_valid && $stable(ins_char) && $stable(ins_ptr_r))
    else $error("insert character changed before it was taken");
  detect_two_a: assert property (@(posedge clock) disable iff (rst)
    det_valid && cfg.detect_en && !cfg.detect_one && !prev_hit_r |=> !eol_detected)
    else $error("two character detect fired without a first match");
  status_read_a: assert property (@(posedge clock) disable iff (rst)
    rd_index == `CCR_IDX_HSCS |=> rd_data[`CCR_HS_DATA_ACK_IN] == $past(data_ack_in_true)
      && rd_data[`CCR_HS_READY_IN] == $past(ready_in_true))
    else $error("handshake status bits not reported");
  core_follow_a: assert property (@(posedge clock) disable iff (rst)
    !regs_r[`CCR_IDX_HSCS][`CCR_HS_DIRECT] |=> data_ack_out == ($past(core_data_ack) ^ $past(cfg.hs_neg)))
    else $error("data ack pin does not follow the core");

  pulse_seen_c: cover property (@(posedge clock) disable iff (rst) $fell(dv_active_r));
  insert_run_c: cover property (@(posedge clock) disable iff (rst)
    ins_valid && ins_ready && ins_ptr_r == `CCR_IDX_INS_LAST);
  detect_two_c: cover property (@(posedge clock) disable iff (rst) eol_detected && !cfg.detect_one);
  direct_ctl_c: cover property (@(posedge clock) disable iff (rst) regs_r[`CCR_IDX_HSCS][`CCR_HS_DIRECT] && ready_out);
  zero_pulse_c: cover property (@(posedge clock) disable iff (rst) $fell(dv_active_r) && regs_r[`CCR_IDX_PW] == 8'h00);
endmodule // ccr_bank
`default_nettype wire

// ==== rtl/ccr_cfg.svh ====
// constants for the converter control register bank
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH
`define CCR_NUM_REGS 19
`define CCR_IDX_W 5
`define CCR_IDX_SRQ 5'h00
`define CCR_IDX_HSCS 5'h01
`define CCR_IDX_FMT 5'h02
`define CCR_IDX_PW 5'h03
`define CCR_IDX_EOLC 5'h04
`define CCR_IDX_INS_FIRST 5'h05
`define CCR_IDX_INS_LAST 5'h0C
`define CCR_IDX_DET_A 5'h0D
`define CCR_IDX_DET_B 5'h0E
`define CCR_NUM_DEFAULTED 5
`define CCR_RST_SRQ 8'h40
`define CCR_RST_HSCS 8'h00
`define CCR_RST_FMT 8'hD8
`define CCR_RST_PW 8'h05
`define CCR_RST_EOLC 8'h00
`define CCR_HSCS_WMASK 8'hB8
`define CCR_DDL_SEC 5'h00
`define CCR_HS_DIRECT 7
`define CCR_HS_DACK 5
`define CCR_HS_BEMPTY 4
`define CCR_HS_RDY 3
`define CCR_HS_DATA_ACK_IN 2
`define CCR_HS_READY_IN 0
`define CCR_FMT_OPT_HI 7
`define CCR_FMT_OPT_LO 6
`define CCR_FMT_DNEG 5
`define CCR_FMT_HNEG 4
`define CCR_FMT_UNIT 3
`define CCR_FMT_WIDE 2
`define CCR_FMT_UNI 1
`define CCR_FMT_TMO 0
`define CCR_EOL_DET 7
`define CCR_EOL_DET1 6
`define CCR_EOL_INS 3
`define CCR_EOL_CNT_HI 2
`define CCR_EOL_CNT_LO 0
`define CCR_PW_ZERO_UNITS 256
`define CCR_CLK_NS 10
`define CCR_T_BASE_NS 25000
`define CCR_T_MIN_NS 40000
`define CCR_T_UNIT_LONG_NS 100000
`define CCR_T_UNIT_SHORT_NS 5000
`define CCR_DUR_W 22
`endif

// ==== rtl/ccr_pkg.sv ====
// types of the converter control register bank
`default_nettype none
package ccr_pkg;
  typedef struct packed {
    logic valid;
    logic [4:0] secondary;
    logic [4:0] index;
    logic [7:0] data;
  } ccr_wr_type;
  typedef struct packed {
    logic [1:0] hs_option;
    logic data_neg;
    logic hs_neg;
    logic unit_short;
    logic wide16;
    logic unidir;
    logic timeout_en;
    logic buf_empty_eod;
    logic detect_en;
    logic detect_one;
    logic insert_en;
    logic [2:0] insert_cnt;
  } ccr_cfg_type;
  typedef enum logic [1:0] {
    CCR_IDLE = 2'b01,
    CCR_EMIT = 2'b10
  } ccr_state_type;
endpackage
`default_nettype wire

// ==== verif/ccr_loop_ctl.sv ====
// loop controller model that sends register write messages
`timescale 1ns/1ns
`default_nettype none
module ccr_loop_ctl (
  input wire logic clock, // system clock
  output var ccr_pkg::ccr_wr_type wr // register write message
);
  initial wr = '0;

  // one write message, then the port goes idle
  task automatic send(input logic [4:0] idx, input logic [4:0] sec, input logic [7:0] d);
    @(posedge clock);
    wr <= {1'b1, sec, idx, d};
    @(posedge clock);
    wr <= '0;
  endtask
endmodule // ccr_loop_ctl
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the converter control register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int BASE = 5;
  localparam int MINC = 8;
  localparam int ULONG = 20;
  localparam int USHORT = 1;
  logic clock, rst, srq_out, strobe_start, strobe_busy, data_valid_out, insert_start, ins_valid;
  logic ins_ready, det_valid, eol_detected, core_data_ack, core_ready, data_ack_in, ready_in;
  logic data_ack_out, ready_out, dai_true, rdi_true;
  logic [4:0] rd_index;
  logic [7:0] rd_data, req_src, ins_char, det_char;
  logic [7:0] exp [19];
  ccr_pkg::ccr_wr_type wr;
  ccr_pkg::ccr_cfg_type cfg;
  int fails, n_compared, cycles;

  ccr_loop_ctl ctl (.clock(clock), .wr(wr));
  ccr_bank #(.BASE_CYC(BASE), .MIN_CYC(MINC), .UNIT_LONG_CYC(ULONG), .UNIT_SHORT_CYC(USHORT)) DUT (
    .clock(clock), .rst(rst), .wr(wr), .rd_index(rd_index), .rd_data(rd_data), .req_src(req_src),
    .srq_out(srq_out), .cfg(cfg), .core_data_ack(core_data_ack), .core_ready(core_ready),
    .data_ack_in(data_ack_in), .ready_in(ready_in), .data_ack_out(data_ack_out), .ready_out(ready_out),
    .data_ack_in_true(dai_true), .ready_in_true(rdi_true), .strobe_start(strobe_start), .strobe_busy(strobe_busy),
    .data_valid_out(data_valid_out), .insert_start(insert_start), .ins_valid(ins_valid),
    .ins_ready(ins_ready), .ins_char(ins_char), .det_valid(det_valid), .det_char(det_char),
    .eol_detected(eol_detected));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic rdchk(input logic [4:0] i, input logic [7:0] want);
    @(posedge clock);
    rd_index <= i;
    @(posedge clock);
    #1 check($sformatf("reg %0d", i), {8'h00, rd_data}, {8'h00, want});
  endtask

  function automatic int dur_of(input bit short_unit, input int n);
    int d;
    d = BASE + (n == 0 ? 256 : n) * (short_unit ? USHORT : ULONG);
    return d < MINC ? MINC : d;
  endfunction

  task automatic strobe(input logic [7:0] f, input logic [7:0] n);
    int k;
    ctl.send(5'h02, 5'h00, f);
    ctl.send(5'h03, 5'h00, n);
    @(posedge clock);
    strobe_start <= 1'b1;
    @(posedge clock);
    strobe_start <= 1'b0;
    #1 k = 0;
    while (strobe_busy === 1'b1 && k < 400) begin
      check("data_valid_out", {15'h0000, data_valid_out}, 16'h0001);
      k++;
      @(posedge clock);
      #1;
    end
    check("pulse length", 16'(k), 16'(dur_of(f[3], int'(n))));
    check("data_valid_out idle", {15'h0000, data_valid_out}, 16'h0000);
  endtask

  task automatic det(input logic [7:0] c, input logic want);
    @(posedge clock);
    det_valid <= 1'b1;
    det_char <= c;
    @(posedge clock);
    det_valid <= 1'b0;
    #1 check("eol_detected", {15'h0000, eol_detected}, {15'h0000, want});
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1; rd_index = '0; req_src = '0; core_data_ack = 1'b0; core_ready = 1'b0;
    data_ack_in = 1'b1; ready_in = 1'b1; strobe_start = 1'b0; insert_start = 1'b0;
    ins_ready = 1'b1; det_valid = 1'b0; det_char = '0; fails = 0; n_compared = 0; cycles = 0;
    exp = '{default: 8'h00};
    exp[0] = 8'h40;
    exp[2] = 8'hD8;
    exp[3] = 8'h05;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 check("cfg default", {1'b0, cfg}, 16'h6C00);
    check("data_valid_out reset", {15'h0000, data_valid_out}, 16'h0001);
    for (int i = 0; i < 5; i++) rdchk(5'(i), exp[i]);
    req_src <= 8'h40;
    repeat (3) @(posedge clock);
    #1 check("srq_out on", {15'h0000, srq_out}, 16'h0001);
    req_src <= 8'hBF;
    repeat (3) @(posedge clock);
    #1 check("srq_out off", {15'h0000, srq_out}, 16'h0000);
    $display("test defaults done");

    for (int i = 5; i < 19; i++) begin
      exp[i] = 8'(i * 37 + 3);
      ctl.send(5'(i), 5'h00, exp[i]);
    end
    ctl.send(5'h05, 5'h01, 8'hFF);
    ctl.send(5'h02, 5'h01, 8'h00);
    ctl.send(5'h14, 5'h00, 8'hFF);
    for (int i = 0; i < 19; i++) rdchk(5'(i), exp[i]);
    rdchk(5'h13, 8'h00);
    $display("test register file done");

    ctl.send(5'h02, 5'h00, 8'hCA);
    @(posedge clock);
    #1 check("cfg format", {1'b0, cfg}, 16'h6500);
    for (int i = 15; i < 19; i++) ctl.send(5'(i), 5'h00, ~exp[i]);
    @(posedge clock);
    #1 check("cfg reserved", {1'b0, cfg}, 16'h6500);
    $display("test format done");

    ctl.send(5'h01, 5'h00, 8'hA0);
    data_ack_in <= 1'b1;
    ready_in <= 1'b0;
    repeat (4) @(posedge clock);
    #1 check("data_ack_out", {14'h0000, data_ack_out, ready_out}, 16'h0002);
    check("input status", {14'h0000, dai_true, rdi_true}, 16'h0002);
    rdchk(5'h01, 8'hA4);
    ctl.send(5'h01, 5'h00, 8'h88);
    data_ack_in <= 1'b0;
    ready_in <= 1'b1;
    repeat (4) @(posedge clock);
    #1 check("ready_out", {14'h0000, data_ack_out, ready_out}, 16'h0001);
    check("input status", {14'h0000, dai_true, rdi_true}, 16'h0001);
    rdchk(5'h01, 8'h89);
    ctl.send(5'h01, 5'h00, 8'h00);
    core_data_ack <= 1'b1;
    repeat (2) @(posedge clock);
    #1 check("core path", {14'h0000, data_ack_out, ready_out}, 16'h0002);
    core_data_ack <= 1'b0;
    $display("test handshake done");

    strobe(8'hCA, 8'h05);
    strobe(8'hCA, 8'h01);
    strobe(8'hCA, 8'h00);
    strobe(8'hC2, 8'h01);
    $display("test strobe done");

    for (int c = 0; c < 8; c++) begin
      ctl.send(5'h04, 5'h00, 8'h08 | 8'(c));
      @(posedge clock);
      insert_start <= 1'b1;
      @(posedge clock);
      insert_start <= 1'b0;
      #1;
      for (int j = 12 - c; j <= 12; j++) begin
        check("ins_valid", {15'h0000, ins_valid}, 16'h0001);
        check("ins_char", {8'h00, ins_char}, {8'h00, exp[j]});
        @(posedge clock);
        #1;
      end
      check("ins_valid end", {15'h0000, ins_valid}, 16'h0000);
    end
    ins_ready <= 1'b0;
    ctl.send(5'h04, 5'h00, 8'h09);
    @(posedge clock);
    insert_start <= 1'b1;
    @(posedge clock);
    insert_start <= 1'b0;
    repeat (3) @(posedge clock);
    #1 check("ins_valid held", {15'h0000, ins_valid}, 16'h0001);
    check("ins_char held", {8'h00, ins_char}, {8'h00, exp[11]});
    ins_ready <= 1'b1;
    ctl.send(5'h04, 5'h00, 8'h07);
    @(posedge clock);
    insert_start <= 1'b1;
    @(posedge clock);
    insert_start <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check("ins_valid off", {15'h0000, ins_valid}, 16'h0000);
    $display("test insert done");

    ctl.send(5'h04, 5'h00, 8'hC0);
    det(exp[13], 1'b1);
    det(exp[14], 1'b0);
    ctl.send(5'h04, 5'h00, 8'h80);
    det(exp[13], 1'b0);
    det(exp[14], 1'b1);
    $display("test detect done");
    summarize();
  end
endmodule // testbench
`default_nettype wire
